//--- core/pft_defines.svh
`ifndef PFT_DEFINES_SVH
`define PFT_DEFINES_SVH

// ****************************************************************
// Register offsets (byte addresses on the register bus)
// ****************************************************************
`define PFT_OFS_CTRL 8'h00
`define PFT_OFS_IRQ 8'h04
`define PFT_OFS_CNT_LO 8'h08
`define PFT_OFS_CNT_HI 8'h0C
`define PFT_OFS_IEN 8'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define PFT_CTRL_SRC_LSB 0
`define PFT_CTRL_DIV_LSB 2
`define PFT_CTRL_BYTE_FLAG 4
`define PFT_CTRL_CLR_EN 5
`define PFT_CTRL_BYTE_SEL 6
`define PFT_CTRL_FULL_SEL 7
`define PFT_IRQ_FULL_FLAG 7
`define PFT_IEN_ENABLE 7

// ****************************************************************
// Reset values
// ****************************************************************
`define PFT_CTRL_RESET 8'h00
`define PFT_IEN_RESET 1'b0
`define PFT_COUNT_RESET 16'h0000

// ****************************************************************
// Timing counts in oscillator clocks
// ****************************************************************
`define PFT_MC_LAST 4'hB
`define PFT_PHASE_FIRST 4'h2
`define PFT_PHASE_SECOND 4'h8

`endif

//--- core/pft_pkg.sv
package pft_pkg;

    typedef enum logic [1:0] {
        SRC_OFF,
        SRC_OSC,
        SRC_EXT,
        SRC_SPARE
    } source_t;

    typedef enum logic [1:0] {
        DIV_1,
        DIV_2,
        DIV_4,
        DIV_8
    } divide_t;

endpackage : pft_pkg

//--- core/pin_edge_sampler.sv
`timescale 1ns/1ns

// ****************************************************************
// Pin synchroniser with strobed rising-edge detection
// ****************************************************************
module pin_edge_sampler (
    // Clock, reset and enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Pin and sampling strobe
    input wire logic pin_async,
    input wire logic sample_stb,
    // Edge seen between two consecutive samples
    output logic rise
);

    logic sync1_ff;
    logic sync2_ff;
    logic last_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end else if (ce) begin
            sync1_ff <= pin_async;
            sync2_ff <= sync1_ff;
        end
    end

    // Reset to high so a pin that is high at start-up is no edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_ff <= 1'b1;
        end else if (ce && sample_stb) begin
            last_ff <= sync2_ff;
        end
    end

    assign rise = sample_stb & ~last_ff & sync2_ff;

endmodule : pin_edge_sampler

//--- core/prescaled_free_running_timer.sv
// Operation
// - Sixteen-bit up-counter kept as high and low bytes, both readable.
// - Clock source is off, oscillator over twelve, or external pin, via prescaler.
// - Each external rising edge advances the prescaler, at most once per cycle.
// - External pin sampled at two fixed phases; low then high means edge.
// - Early edge counts next machine cycle; late edge counts one cycle later.
// - Prescaler divides by a programmed factor of 1, 2, 4 or 8.
// - Prescaler clears on divide or source change and on counter reset.
// - Count readable on the fly without latch; software cannot load it.
// - Chip reset clears counter; enabled clear-pin rising edge also clears it.
// - Byte and full overflow flags set one machine cycle after overflow.
// - Setting the full overflow flag also sets the byte overflow flag.
// - Byte overflow request needs the irq enable and byte select bits.
// - Full overflow request needs irq enable and full select; flag is bit seven.
// - Both overflow sources share one interrupt request line.
// - Overflow flags stay set until software clears them.
// - Idle mode holds counter and prescaler cleared and halted.
`timescale 1ns/1ns
`include "pft_defines.svh"

module prescaled_free_running_timer
    import pft_pkg::*;
(
    // Clock, reset and enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins and power state
    input wire logic ext_count_pin,
    input wire logic ext_clear_pin,
    input wire logic idle_mode,
    // Shared overflow interrupt request
    output logic irq_req
);

    // ****************************************************************
    // Machine cycle phase
    // ****************************************************************
    logic [3:0] phase_ff;
    logic boundary, at_first, at_second;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_ff <= 4'h0;
        end else if (ce) begin
            phase_ff <= boundary ? 4'h0 : phase_ff + 4'h1;
        end
    end

    assign boundary = (phase_ff == `PFT_MC_LAST);
    assign at_first = (phase_ff == `PFT_PHASE_FIRST);
    assign at_second = (phase_ff == `PFT_PHASE_SECOND);

    // ****************************************************************
    // Register bus decode
    // ****************************************************************
    logic [7:0] ctrl_ff;
    logic full_flag_ff;
    logic counter_irq_enable_ff;
    logic [7:0] count_low_byte_ff;
    logic [7:0] count_high_byte_ff;
    logic setup, access_wr, mapped;
    logic wr_ctrl, wr_irq, wr_ien;

    assign setup = psel & ~penable;
    assign access_wr = psel & penable & pready & pwrite;
    assign mapped = (paddr == `PFT_OFS_CTRL) || (paddr == `PFT_OFS_IRQ) || (paddr == `PFT_OFS_CNT_LO)
                    || (paddr == `PFT_OFS_CNT_HI) || (paddr == `PFT_OFS_IEN);
    assign wr_ctrl = access_wr & (paddr == `PFT_OFS_CTRL);
    assign wr_irq = access_wr & (paddr == `PFT_OFS_IRQ);
    assign wr_ien = access_wr & (paddr == `PFT_OFS_IEN);

    // Every transfer answers in the access cycle right after setup.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= setup;
            pslverr <= setup & ~mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (ce && setup && !pwrite) begin
            case (paddr)
                `PFT_OFS_CTRL: prdata <= {24'h000000, ctrl_ff};
                `PFT_OFS_IRQ: prdata <= {24'h000000, full_flag_ff, 7'h00};
                `PFT_OFS_CNT_LO: prdata <= {24'h000000, count_low_byte_ff};
                `PFT_OFS_CNT_HI: prdata <= {24'h000000, count_high_byte_ff};
                `PFT_OFS_IEN: prdata <= {24'h000000, counter_irq_enable_ff, 7'h00};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // Control register and interrupt enable
    // ****************************************************************
    source_t source;
    divide_t divide;
    logic byte_overflow_flag, cfg_change, set_byte, set_full;

    assign source = source_t'(ctrl_ff[`PFT_CTRL_SRC_LSB +: 2]);
    assign divide = divide_t'(ctrl_ff[`PFT_CTRL_DIV_LSB +: 2]);
    assign byte_overflow_flag = ctrl_ff[`PFT_CTRL_BYTE_FLAG];
    assign cfg_change = wr_ctrl & (pwdata[3:0] != ctrl_ff[3:0]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `PFT_CTRL_RESET;
        end else if (ce) begin
            if (wr_ctrl) begin
                ctrl_ff <= pwdata[7:0];
            end
            // A hardware set in the same cycle as a software clear wins.
            if (set_byte) begin
                ctrl_ff[`PFT_CTRL_BYTE_FLAG] <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full_flag_ff <= 1'b0;
        end else if (ce) begin
            if (set_full) begin
                full_flag_ff <= 1'b1;
            end else if (wr_irq) begin
                full_flag_ff <= pwdata[`PFT_IRQ_FULL_FLAG];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_irq_enable_ff <= `PFT_IEN_RESET;
        end else if (ce && wr_ien) begin
            counter_irq_enable_ff <= pwdata[`PFT_IEN_ENABLE];
        end
    end

    // ****************************************************************
    // External pins
    // ****************************************************************
    logic count_rise, clear_rise, sample_stb;

    assign sample_stb = at_first | at_second;

    pin_edge_sampler count_sampler (
        .pclk(pclk), .presetn(presetn), .ce(ce),
        .pin_async(ext_count_pin), .sample_stb(sample_stb), .rise(count_rise)
    );

    pin_edge_sampler clear_sampler (
        .pclk(pclk), .presetn(presetn), .ce(ce),
        .pin_async(ext_clear_pin), .sample_stb(sample_stb), .rise(clear_rise)
    );

    logic timer_clear;

    assign timer_clear = idle_mode | (clear_rise & ctrl_ff[`PFT_CTRL_CLR_EN]);

    // ****************************************************************
    // Edge scheduling
    // ****************************************************************
    logic pend_next_ff;
    logic pend_later_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_next_ff <= 1'b0;
            pend_later_ff <= 1'b0;
        end else if (ce) begin
            if (timer_clear) begin
                pend_next_ff <= 1'b0;
                pend_later_ff <= 1'b0;
            end else if (boundary) begin
                pend_next_ff <= pend_later_ff;
                pend_later_ff <= 1'b0;
            end else if (count_rise && at_first) begin
                pend_next_ff <= 1'b1;
            end else if (count_rise && at_second) begin
                pend_later_ff <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Prescaler
    // ****************************************************************
    logic presc_in, tick;
    logic [2:0] presc_ff, presc_max;

    always_comb begin
        case (source)
            SRC_OSC: presc_in = boundary;
            SRC_EXT: presc_in = boundary & pend_next_ff;
            SRC_OFF: presc_in = 1'b0;
            default: presc_in = 1'b0;
        endcase
    end

    always_comb begin
        case (divide)
            DIV_1: presc_max = 3'h0;
            DIV_2: presc_max = 3'h1;
            DIV_4: presc_max = 3'h3;
            DIV_8: presc_max = 3'h7;
            default: presc_max = 3'h0;
        endcase
    end

    assign tick = presc_in & (presc_ff == presc_max) & ~timer_clear & ~cfg_change;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_ff <= 3'h0;
        end else if (ce) begin
            if (timer_clear || cfg_change || tick) begin
                presc_ff <= 3'h0;
            end else if (presc_in) begin
                presc_ff <= presc_ff + 3'h1;
            end
        end
    end

    // ****************************************************************
    // Counter
    // ****************************************************************
    localparam logic [15:0] count_reset = `PFT_COUNT_RESET;
    logic low_wrap, full_wrap;

    assign low_wrap = (count_low_byte_ff == 8'hFF);
    assign full_wrap = low_wrap & (count_high_byte_ff == 8'hFF);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_low_byte_ff <= count_reset[7:0];
            count_high_byte_ff <= count_reset[15:8];
        end else if (ce) begin
            if (timer_clear) begin
                count_low_byte_ff <= count_reset[7:0];
                count_high_byte_ff <= count_reset[15:8];
            end else if (tick) begin
                count_low_byte_ff <= count_low_byte_ff + 8'h01;
                if (low_wrap) begin
                    count_high_byte_ff <= count_high_byte_ff + 8'h01;
                end
            end
        end
    end

    // ****************************************************************
    // Overflow flags
    // ****************************************************************
    logic byte_pend_ff, full_pend_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            byte_pend_ff <= 1'b0;
            full_pend_ff <= 1'b0;
        end else if (ce && boundary) begin
            byte_pend_ff <= tick & low_wrap;
            full_pend_ff <= tick & full_wrap;
        end
    end

    assign set_byte = boundary & byte_pend_ff;
    assign set_full = boundary & full_pend_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_req <= 1'b0;
        end else if (ce) begin
            irq_req <= counter_irq_enable_ff & ((byte_overflow_flag & ctrl_ff[`PFT_CTRL_BYTE_SEL])
                                                | (full_flag_ff & ctrl_ff[`PFT_CTRL_FULL_SEL]));
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_count_step: assert property (@(posedge pclk) disable iff (!presetn)
        ce && tick && !timer_clear |=> {count_high_byte_ff, count_low_byte_ff}
            == $past({count_high_byte_ff, count_low_byte_ff}) + 16'h0001)
        else $error("count did not advance by one on a tick");
    chk_off_holds: assert property (@(posedge pclk) disable iff (!presetn)
        ce && source == SRC_OFF && !timer_clear && !cfg_change |=> $stable(presc_ff)
            && $stable({count_high_byte_ff, count_low_byte_ff}))
        else $error("counter moved with source off");
    chk_edge_early: assert property (@(posedge pclk) disable iff (!presetn)
        ce && count_rise && at_first && !timer_clear |=> pend_next_ff)
        else $error("early edge not scheduled for next cycle");
    chk_edge_late: assert property (@(posedge pclk) disable iff (!presetn)
        ce && count_rise && at_second && !timer_clear |=> pend_later_ff && $stable(pend_next_ff))
        else $error("late edge not delayed by one more cycle");
    chk_cfg_clear: assert property (@(posedge pclk) disable iff (!presetn)
        ce && cfg_change |=> presc_ff == 3'h0)
        else $error("prescaler kept value over config change");
    chk_idle_clear: assert property (@(posedge pclk) disable iff (!presetn)
        ce && idle_mode |=> presc_ff == 3'h0 && count_low_byte_ff == 8'h00 && count_high_byte_ff == 8'h00)
        else $error("idle did not clear timer");
    chk_ext_clear: assert property (@(posedge pclk) disable iff (!presetn)
        ce && clear_rise && ctrl_ff[`PFT_CTRL_CLR_EN] |=> {count_high_byte_ff, count_low_byte_ff} == 16'h0000)
        else $error("enabled clear edge did not clear counter");
    chk_flag_delay: assert property (@(posedge pclk) disable iff (!presetn)
        ce && boundary && tick && low_wrap |=> byte_pend_ff)
        else $error("byte overflow not held for the next cycle");
    chk_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        ce && set_byte |=> byte_overflow_flag)
        else $error("byte flag not set one cycle after overflow");
    chk_full_both: assert property (@(posedge pclk) disable iff (!presetn)
        ce && set_full |=> full_flag_ff && byte_overflow_flag)
        else $error("full overflow without byte flag");
    chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        full_flag_ff && !wr_irq |=> full_flag_ff)
        else $error("full flag cleared without software write");
    chk_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !counter_irq_enable_ff |=> !irq_req)
        else $error("request raised with interrupt disabled");
    chk_irq_full: assert property (@(posedge pclk) disable iff (!presetn)
        ce && counter_irq_enable_ff && full_flag_ff && ctrl_ff[`PFT_CTRL_FULL_SEL] |=> irq_req)
        else $error("full overflow request missing");
    chk_bus_answer: assert property (@(posedge pclk) disable iff (!presetn)
        ce && setup |=> pready && pslverr == !$past(mapped))
        else $error("bus answer not given in access cycle");

endmodule : prescaled_free_running_timer

//--- test/pin_pulse_source.sv
`timescale 1ns/1ns

// ****************************************************************
// External count and clear pulse sources
// ****************************************************************
module pin_pulse_source (
    // Clock
    input wire logic pclk,
    // Pins towards the timer
    output logic count_pin,
    output logic clear_pin
);

    // Both lines rest low between pulses, as if pulled down.
    initial begin
        count_pin = 1'b0;
        clear_pin = 1'b0;
    end

    task automatic pulse(input int n, input bit on_clear, input int hold);
        repeat (n) begin
            repeat (hold) @(posedge pclk);
            if (on_clear) begin
                clear_pin <= 1'b1;
            end else begin
                count_pin <= 1'b1;
            end
            repeat (hold) @(posedge pclk);
            clear_pin <= 1'b0;
            count_pin <= 1'b0;
        end
    endtask : pulse

endmodule : pin_pulse_source

//--- test/prescaled_free_running_timer_tb.sv
`timescale 1ns/1ns
`include "pft_defines.svh"

module prescaled_free_running_timer_tb;

    logic pclk, presetn, ce, psel, penable, pwrite, idle_mode, pready, pslverr, irq_req, err;
    logic ext_count_pin, ext_clear_pin;
    logic [7:0] paddr, a;
    logic [31:0] pwdata, prdata, rd;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    int lat, n, k;

    // ****************************************************************
    // Design and pin sources
    // ****************************************************************
    prescaled_free_running_timer i_prescaled_free_running_timer (
        .pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_count_pin(ext_count_pin), .ext_clear_pin(ext_clear_pin), .idle_mode(idle_mode),
        .irq_req(irq_req)
    );

    pin_pulse_source i_pin_pulse_source (.pclk(pclk), .count_pin(ext_count_pin), .clear_pin(ext_clear_pin));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            close_out();
        end
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        if (fail_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    // One APB transfer; lat returns the edges spent, setup edge included.
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        lat = 2;
        do begin
            @(posedge pclk);
            lat = lat + 1;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [7:0] exp_ticks(input int events, input int div_code);
        return 8'(events >> div_code);
    endfunction : exp_ticks

    task automatic irq_is(input logic v);
        repeat (2) @(posedge pclk);
        check({31'h0, irq_req}, {31'h0, v});
    endtask : irq_is

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        idle_mode = 1'b0;
        ce = 1'b1;
        presetn = 1'b0;
        k = $urandom(71);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `PFT_OFS_CTRL, 32'h0); check(rd, 32'h0);
        apb(1'b0, `PFT_OFS_IRQ, 32'h0); check(rd, 32'h0);
        apb(1'b0, `PFT_OFS_IEN, 32'h0); check(rd, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b1, `PFT_OFS_CNT_LO, 32'hA5);
        apb(1'b1, `PFT_OFS_CNT_HI, 32'h5A);
        apb(1'b0, `PFT_OFS_CNT_LO, 32'h0); check(rd, 32'h0);
        apb(1'b0, `PFT_OFS_CNT_HI, 32'h0); check(rd, 32'h0);
        for (int d = 0; d < 4; d++) begin
            apb(1'b1, `PFT_OFS_CTRL, {28'h0, 2'(d), 2'b01});
            k = 1 + $urandom_range(3);
            apb(1'b0, `PFT_OFS_CNT_LO, 32'h0);
            a = rd[7:0];
            repeat (12 * (1 << d) * k - lat) @(posedge pclk);
            apb(1'b0, `PFT_OFS_CNT_LO, 32'h0);
            check({24'h0, 8'(rd[7:0] - a)}, {24'h0, exp_ticks(k << d, d)});
        end
        apb(1'b1, `PFT_OFS_IEN, 32'h80);
        apb(1'b1, `PFT_OFS_CTRL, 32'h01);
        n = 0;
        do begin
            apb(1'b0, `PFT_OFS_CTRL, 32'h0);
            n = n + 1;
        end while (rd[4] !== 1'b1 && n < 1500);
        check(rd, 32'h11);
        apb(1'b0, `PFT_OFS_CNT_LO, 32'h0); check(rd, 32'h01);
        irq_is(1'b0);
        apb(1'b1, `PFT_OFS_CTRL, 32'h51);
        irq_is(1'b1);
        repeat (30) @(posedge pclk);
        apb(1'b0, `PFT_OFS_CTRL, 32'h0); check(rd, 32'h51);
        apb(1'b1, `PFT_OFS_IEN, 32'h00);
        irq_is(1'b0);
        apb(1'b1, `PFT_OFS_IEN, 32'h80);
        apb(1'b1, `PFT_OFS_CTRL, 32'h41);
        irq_is(1'b0);
        apb(1'b1, `PFT_OFS_IRQ, 32'h80);
        apb(1'b0, `PFT_OFS_IRQ, 32'h0); check(rd, 32'h80);
        apb(1'b1, `PFT_OFS_CTRL, 32'h01);
        irq_is(1'b0);
        apb(1'b1, `PFT_OFS_CTRL, 32'h81);
        irq_is(1'b1);
        apb(1'b1, `PFT_OFS_IRQ, 32'h00);
        irq_is(1'b0);
        // Plain off and the spare source code must both hold the count.
        for (int s = 0; s < 4; s += 3) begin
            apb(1'b1, `PFT_OFS_CTRL, 32'(s));
            apb(1'b0, `PFT_OFS_CNT_LO, 32'h0);
            a = rd[7:0];
            repeat (60) @(posedge pclk);
            apb(1'b0, `PFT_OFS_CNT_LO, 32'h0); check(rd, {24'h0, a});
        end
        for (int d = 0; d < 2; d++) begin
            apb(1'b1, `PFT_OFS_CTRL, {28'h0, 2'(d), 2'b10});
            apb(1'b0, `PFT_OFS_CNT_LO, 32'h0);
            a = rd[7:0];
            k = 1 + $urandom_range(5);
            i_pin_pulse_source.pulse(k << d, 1'b0, 6 + $urandom_range(4));
            repeat (40) @(posedge pclk);
            apb(1'b0, `PFT_OFS_CNT_LO, 32'h0);
            check({24'h0, 8'(rd[7:0] - a)}, {24'h0, exp_ticks(k << d, d)});
        end
        a = rd[7:0];
        i_pin_pulse_source.pulse(1, 1'b1, 8);
        repeat (40) @(posedge pclk);
        apb(1'b0, `PFT_OFS_CNT_LO, 32'h0); check(rd, {24'h0, a});
        apb(1'b1, `PFT_OFS_CTRL, 32'h26);
        i_pin_pulse_source.pulse(1, 1'b1, 8);
        repeat (40) @(posedge pclk);
        apb(1'b0, `PFT_OFS_CNT_LO, 32'h0); check(rd, 32'h0);
        apb(1'b1, `PFT_OFS_CTRL, 32'h01);
        repeat (50) @(posedge pclk);
        // Freeze the block for 120 edges; only the three live edges around it may tick.
        apb(1'b0, `PFT_OFS_CNT_LO, 32'h0);
        a = rd[7:0];
        ce <= 1'b0;
        repeat (120) @(posedge pclk);
        ce <= 1'b1;
        apb(1'b0, `PFT_OFS_CNT_LO, 32'h0);
        check({31'h0, 8'(rd[7:0] - a) < 8'h02}, 32'h1);
        idle_mode <= 1'b1;
        repeat (30) @(posedge pclk);
        apb(1'b0, `PFT_OFS_CNT_LO, 32'h0); check(rd, 32'h0);
        repeat (100) @(posedge pclk);
        apb(1'b0, `PFT_OFS_CNT_LO, 32'h0); check(rd, 32'h0);
        apb(1'b0, `PFT_OFS_CNT_HI, 32'h0); check(rd, 32'h0);
        idle_mode <= 1'b0;
        close_out();
    end

endmodule : prescaled_free_running_timer_tb
